// ### rtl/hdf_pkg.sv
// Shared constants for the HDLC DMA and FIFO interface block.
package hdf_pkg;
    // =========================================================
    // Sizes
    localparam int HDF_DATA_W = 8;
    localparam int HDF_HALF_BYTES = 32;
    localparam int HDF_FIFO_BYTES = 64;
    localparam int HDF_IN_DEPTH = 16;
    localparam int HDF_CNT_W = 7;
    localparam int HDF_PTR_W = 6;
    localparam int HDF_MAX_SHORT_FRAMES = 17;
    localparam int HDF_FRM_W = 5;
    localparam int HDF_NUM_CH = 2;
    // =========================================================
    // Reset values
    localparam logic HDF_DMA_MODE_RST = 1'b0;
endpackage

// ### rtl/hdf_fifo.sv
// Parameterised valid/ready FIFO used on the receive data path.
`timescale 1ns/1ps
`default_nettype none
module hdf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } hdf_fifo_st_t;
    hdf_fifo_st_t st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign o_in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_reg.cnt != '0);
    assign o_out_data = mem[st_reg.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (i_sys_rst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st_reg <= st_next;
        if (push) begin
            mem[st_reg.wr] <= i_in_data;
        end
    end
endmodule
`default_nettype wire

// ### rtl/hdf_dma_if.sv
// DMA request logic and split 64-byte transmit and receive FIFOs for two channels.
// How it works
// - Two channels, each with transmit request, receive request and acknowledge.
// - Requests are levels held while the FIFO still needs transfers.
// - With acknowledge high, a bus cycle reaches the FIFO top without address.
// - Request drops as soon as the final cycle of the block starts.
// - Transmit request stays up until a write cycle clears it.
// - Data moves in blocks of at most 32 bytes.
// - Each FIFO is 64 bytes in two halves; one half visible at a time.
// - After 32 received bytes, raise pool-full or the receive request.
// - Receive block held until command release or the DMA read of its last byte (32 for a full block, fewer for a frame tail).
// - In interrupt mode the visible block can be reread until released.
// - Long frames keep requesting successive 32-byte blocks.
// - Receive FIFO holds up to 17 short frames.
// - Address field not stored; control first, status byte after each frame.
// - Reset gives interrupt mode; a per-channel bit selects DMA mode (here the mode is the i_dma_mode input, which reset does not touch).
// - Pool-full only in interrupt mode; DMA message end after full readout.
// - Frame overflow when the FIFO is full at a new frame start.
`timescale 1ns/1ps
`default_nettype none
module hdf_dma_if
    import hdf_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Per-channel configuration.
    input wire logic [HDF_NUM_CH-1:0] i_dma_mode,
    input wire logic [HDF_NUM_CH-1:0] i_rx_message_complete_cmd,
    // Bus side, asynchronous strobes from the pins.
    input wire logic [HDF_NUM_CH-1:0] i_dma_acknowledge_in,
    input wire logic [HDF_NUM_CH-1:0] i_fifo_sel,
    input wire logic i_bus_rd,
    input wire logic i_bus_wr,
    input wire logic [HDF_DATA_W-1:0] i_bus_wdata,
    output logic [HDF_DATA_W-1:0] o_bus_rdata,
    output logic [HDF_NUM_CH-1:0] o_tx_dma_request,
    output logic [HDF_NUM_CH-1:0] o_rx_dma_request,
    // Serial engine side.
    input wire logic [HDF_NUM_CH-1:0] i_tx_need,
    input wire logic [HDF_NUM_CH-1:0] i_tx_pop,
    output logic [HDF_NUM_CH*HDF_DATA_W-1:0] o_tx_data,
    output logic [HDF_NUM_CH-1:0] o_tx_avail,
    input wire logic [HDF_NUM_CH-1:0] i_rx_valid,
    output logic [HDF_NUM_CH-1:0] o_rx_ready,
    input wire logic [HDF_NUM_CH*HDF_DATA_W-1:0] i_rx_data,
    input wire logic [HDF_NUM_CH-1:0] i_rx_is_addr,
    input wire logic [HDF_NUM_CH-1:0] i_rx_frame_start,
    input wire logic [HDF_NUM_CH-1:0] i_rx_frame_end,
    input wire logic [HDF_NUM_CH*HDF_DATA_W-1:0] i_rx_status,
    // Events.
    output logic [HDF_NUM_CH-1:0] o_rx_pool_full_irq,
    output logic [HDF_NUM_CH-1:0] o_rx_message_end_irq,
    output logic [HDF_NUM_CH-1:0] o_rx_frame_overflow_irq
);
    // =========================================================
    // Strobe synchronisers
    typedef struct packed {
        logic [2:0] rd;
        logic [2:0] wr;
        logic rd_f;
        logic wr_f;
    } hdf_sync_t;
    hdf_sync_t sy_reg, sy_next;
    logic rd_ev, wr_ev;

    always_comb begin
        sy_next = sy_reg;
        sy_next.rd = {sy_reg.rd[1:0], i_bus_rd};
        sy_next.wr = {sy_reg.wr[1:0], i_bus_wr};
        if (sy_reg.rd[1] == sy_reg.rd[2]) begin
            sy_next.rd_f = sy_reg.rd[2];
        end
        if (sy_reg.wr[1] == sy_reg.wr[2]) begin
            sy_next.wr_f = sy_reg.wr[2];
        end
        if (i_sys_rst) begin
            sy_next = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        sy_reg <= sy_next;
    end

    // Start of a bus cycle once filtered.
    assign rd_ev = (sy_reg.rd[1] == sy_reg.rd[2]) && sy_reg.rd[2] && !sy_reg.rd_f;
    assign wr_ev = (sy_reg.wr[1] == sy_reg.wr[2]) && sy_reg.wr[2] && !sy_reg.wr_f;

    logic [HDF_NUM_CH*HDF_DATA_W-1:0] rdata_ch;

    // =========================================================
    // Per-channel logic
    genvar gc;
    generate
        for (gc = 0; gc < HDF_NUM_CH; gc++) begin : g_ch
            typedef struct packed {
                logic [HDF_PTR_W-1:0] tx_wr;
                logic [HDF_PTR_W-1:0] tx_rd;
                logic [HDF_CNT_W-1:0] tx_cnt;
                logic [HDF_CNT_W-1:0] tx_blk;
                logic [HDF_PTR_W-1:0] rx_wr;
                logic [HDF_PTR_W-1:0] rx_base;
                logic [HDF_CNT_W-1:0] rx_cnt;
                logic [HDF_CNT_W-1:0] rx_vis;
                logic [HDF_CNT_W-1:0] rx_rd;
                logic rx_vis_end;
                logic [HDF_FRM_W-1:0] frames;
                logic in_frame;
                logic st_pend;
                logic pf;
                logic me;
                logic ov;
                logic [HDF_DATA_W-1:0] rdata;
            } hdf_ch_t;
            hdf_ch_t c_reg, c_next;
            logic [HDF_DATA_W-1:0] tx_mem [HDF_FIFO_BYTES];
            logic [HDF_DATA_W-1:0] rx_mem [HDF_FIFO_BYTES];
            logic sel, rd_c, wr_c, dma;
            logic q_valid, q_ready, q_take, q_last;
            logic [HDF_DATA_W:0] q_data;
            logic wr_rx, last_rd, rx_free, released;
            logic [HDF_DATA_W-1:0] wdat;

            assign dma = i_dma_mode[gc];
            assign sel = i_dma_acknowledge_in[gc] || i_fifo_sel[gc];
            assign rd_c = rd_ev && sel;
            assign wr_c = wr_ev && sel;

            hdf_fifo #(
                .WIDTH(HDF_DATA_W + 1),
                .DEPTH(HDF_IN_DEPTH)
            ) u_rx_in (
                .i_clk_sys(i_clk_sys),
                .i_sys_rst(i_sys_rst),
                .i_in_valid(i_rx_valid[gc] && !i_rx_is_addr[gc]),
                .o_in_ready(o_rx_ready[gc]),
                .i_in_data({i_rx_frame_end[gc],
                    i_rx_data[gc*HDF_DATA_W +: HDF_DATA_W]}),
                .o_out_valid(q_valid),
                .i_out_ready(q_ready),
                .o_out_data(q_data)
            );

            // A frame end byte is followed by a status byte.
            assign rx_free = (c_reg.rx_cnt != HDF_CNT_W'(HDF_FIFO_BYTES));
            assign q_ready = rx_free && !c_reg.st_pend;
            assign q_take = q_valid && q_ready;
            assign q_last = q_data[HDF_DATA_W];
            assign wr_rx = q_take || (c_reg.st_pend && rx_free);
            assign wdat = c_reg.st_pend ? i_rx_status[gc*HDF_DATA_W +: HDF_DATA_W]
                : q_data[HDF_DATA_W-1:0];
            assign last_rd = rd_c && dma
                && (c_reg.rx_rd + 1'b1 == c_reg.rx_vis);
            assign released = dma ? last_rd : i_rx_message_complete_cmd[gc];

            always_comb begin
                c_next = c_reg;
                c_next.pf = 1'b0;
                c_next.me = 1'b0;
                c_next.ov = 1'b0;
                // Transmit side: bus writes fill a block of up to 32 bytes.
                if (wr_c && c_reg.tx_cnt != HDF_CNT_W'(HDF_FIFO_BYTES)) begin
                    c_next.tx_wr = c_reg.tx_wr + 1'b1;
                    c_next.tx_blk = c_reg.tx_blk + 1'b1;
                end
                if (i_tx_pop[gc] && c_reg.tx_cnt != '0) begin
                    c_next.tx_rd = c_reg.tx_rd + 1'b1;
                end
                c_next.tx_cnt = c_reg.tx_cnt
                    + HDF_CNT_W'(c_next.tx_wr != c_reg.tx_wr)
                    - HDF_CNT_W'(c_next.tx_rd != c_reg.tx_rd);
                if (c_reg.tx_blk == HDF_CNT_W'(HDF_HALF_BYTES)
                    && c_reg.tx_cnt <= HDF_CNT_W'(HDF_HALF_BYTES)) begin
                    c_next.tx_blk = '0;
                end
                // Receive side: fill the far half.
                if (wr_rx) begin
                    c_next.rx_wr = c_reg.rx_wr + 1'b1;
                    c_next.st_pend = q_take && q_last && !c_reg.st_pend;
                end
                if (i_rx_frame_start[gc]) begin
                    if (!rx_free || c_reg.frames == HDF_FRM_W'(HDF_MAX_SHORT_FRAMES)) begin
                        c_next.ov = 1'b1;
                    end
                    c_next.in_frame = 1'b1;
                end
                if (c_reg.st_pend && rx_free) begin
                    c_next.frames = c_reg.frames + 1'b1;
                    c_next.in_frame = 1'b0;
                end
                // Visible block read.
                if (rd_c && c_reg.rx_vis != '0) begin
                    c_next.rdata = rx_mem[c_reg.rx_base + HDF_PTR_W'(c_reg.rx_rd)];
                    c_next.rx_rd = (c_reg.rx_rd + 1'b1 == c_reg.rx_vis && !dma)
                        ? '0 : c_reg.rx_rd + 1'b1;
                end
                c_next.rx_cnt = c_reg.rx_cnt + HDF_CNT_W'(wr_rx);
                if (c_reg.rx_vis != '0 && released) begin
                    c_next.rx_base = c_reg.rx_base + HDF_PTR_W'(c_reg.rx_vis);
                    c_next.rx_cnt = c_reg.rx_cnt + HDF_CNT_W'(wr_rx) - c_reg.rx_vis;
                    c_next.rx_vis = '0;
                    c_next.rx_rd = '0;
                    if (c_reg.rx_vis_end) begin
                        c_next.frames = c_next.frames - 1'b1;
                        c_next.me = dma;
                    end
                end else if (c_reg.rx_vis == '0) begin
                    // Present a full block or a finished frame tail.
                    if (c_reg.rx_cnt >= HDF_CNT_W'(HDF_HALF_BYTES)) begin
                        c_next.rx_vis = HDF_CNT_W'(HDF_HALF_BYTES);
                        c_next.rx_vis_end = (c_reg.frames != '0) && !c_reg.in_frame;
                        c_next.pf = !dma && c_reg.in_frame;
                        c_next.me = !dma && !c_reg.in_frame;
                    end else if (c_reg.frames != '0 && c_reg.rx_cnt != '0) begin
                        c_next.rx_vis = c_reg.rx_cnt;
                        c_next.rx_vis_end = 1'b1;
                        c_next.me = !dma;
                    end
                end
                if (i_sys_rst) begin
                    c_next = '0;
                end
            end

            always_ff @(posedge i_clk_sys) begin
                c_reg <= c_next;
                if (wr_c && c_reg.tx_cnt != HDF_CNT_W'(HDF_FIFO_BYTES)) begin
                    tx_mem[c_reg.tx_wr] <= i_bus_wdata;
                end
                if (wr_rx) begin
                    rx_mem[c_reg.rx_wr] <= wdat;
                end
            end

            // Requests fall on the start of the cycle that empties the demand.
            assign o_tx_dma_request[gc] = dma && i_tx_need[gc] && !wr_c
                && c_reg.tx_blk < HDF_CNT_W'(HDF_HALF_BYTES - 1)
                && c_reg.tx_cnt <= HDF_CNT_W'(HDF_HALF_BYTES)
                || dma && i_tx_need[gc] && !wr_c
                && c_reg.tx_blk == HDF_CNT_W'(HDF_HALF_BYTES - 1);
            assign o_rx_dma_request[gc] = dma && c_reg.rx_vis != '0 && !last_rd;
            assign o_tx_data[gc*HDF_DATA_W +: HDF_DATA_W] = tx_mem[c_reg.tx_rd];
            assign o_tx_avail[gc] = c_reg.tx_cnt != '0;
            assign rdata_ch[gc*HDF_DATA_W +: HDF_DATA_W] = c_reg.rdata;
            assign o_rx_pool_full_irq[gc] = c_reg.pf;
            assign o_rx_message_end_irq[gc] = c_reg.me;
            assign o_rx_frame_overflow_irq[gc] = c_reg.ov;

            chk_pf_dma_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                dma |=> !c_reg.pf || !$past(dma))
                else $error("Pool-full raised in DMA mode.");
            chk_rxreq_drop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                last_rd |-> !o_rx_dma_request[gc])
                else $error("Receive request held through last read.");
            chk_dma_release: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                last_rd && !i_sys_rst |=> c_reg.rx_vis == '0)
                else $error("Block not released after last DMA read.");
            chk_rx_cap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                c_reg.rx_cnt <= HDF_CNT_W'(HDF_FIFO_BYTES))
                else $error("Receive FIFO over 64 bytes.");
            chk_blk_size: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                c_reg.rx_vis <= HDF_CNT_W'(HDF_HALF_BYTES))
                else $error("Visible block above 32 bytes.");
            chk_frame_cap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                c_reg.frames <= HDF_FRM_W'(HDF_MAX_SHORT_FRAMES))
                else $error("More than 17 frames stored.");
            chk_int_mode: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                !dma |-> !o_rx_dma_request[gc] && !o_tx_dma_request[gc])
                else $error("Request raised in interrupt mode.");
            chk_reread: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                !dma && c_reg.rx_vis != '0 && !released |=> c_reg.rx_vis != '0)
                else $error("Interrupt-mode block dropped without command.");
            chk_txreq_drop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                wr_c |-> !o_tx_dma_request[gc])
                else $error("Transmit request held through a write start.");
            chk_tx_cap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                c_reg.tx_cnt <= HDF_CNT_W'(HDF_FIFO_BYTES))
                else $error("Transmit FIFO over 64 bytes.");
            chk_overflow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
                i_rx_frame_start[gc] && !rx_free |=> c_reg.ov)
                else $error("Overflow not flagged.");
        end
    endgenerate

    // =========================================================
    // Read data return
    always_comb begin
        o_bus_rdata = rdata_ch[HDF_DATA_W-1:0];
        if (i_dma_acknowledge_in[1] || i_fifo_sel[1]) begin
            o_bus_rdata = rdata_ch[HDF_DATA_W +: HDF_DATA_W];
        end
    end
endmodule
`default_nettype wire

// ### tb/hdf_dma_model.sv
// Behavioural DMA controller and bus master on the far side of the block.
`timescale 1ns/1ps
`default_nettype none
module hdf_dma_model
    import hdf_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_auto,
    input wire logic [3:0] i_gap,
    input wire logic [HDF_NUM_CH-1:0] i_rx_req,
    input wire logic [HDF_NUM_CH-1:0] i_tx_req,
    input wire logic [HDF_DATA_W-1:0] i_rdata,
    output logic [HDF_NUM_CH-1:0] o_ack,
    output logic [HDF_NUM_CH-1:0] o_sel,
    output logic o_rd,
    output logic o_wr,
    output logic [HDF_DATA_W-1:0] o_wdata
);
    logic [HDF_DATA_W-1:0] rd_q[$];
    logic [HDF_DATA_W-1:0] rb;
    int wr_count = 0;
    initial begin
        o_ack = '0;
        o_sel = '0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // Strobes stand past the sync and answer delay; released data lines are inverted.
    task automatic cycle(input logic [1:0] ack, input logic [1:0] sel, input logic rd,
                         input logic [7:0] wd, output logic [7:0] data);
        @(negedge i_clk_sys);
        o_ack = ack;
        o_sel = sel;
        o_rd = rd;
        o_wr = !rd;
        o_wdata = wd;
        repeat (6) @(negedge i_clk_sys);
        data = i_rdata;
        o_ack = '0;
        o_sel = '0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = ~wd;
        repeat (4) @(negedge i_clk_sys);
    endtask
    always begin
        @(negedge i_clk_sys);
        if (i_auto) begin
            for (int c = 0; c < HDF_NUM_CH; c++) begin
                if (i_rx_req[c] && !o_ack[c]) begin
                    cycle(2'b01 << c, 2'b00, 1'b1, 8'h00, rb);
                    rd_q.push_back(rb);
                    repeat (i_gap) @(negedge i_clk_sys);
                end else if (i_tx_req[c] && !o_ack[c]) begin
                    cycle(2'b01 << c, 2'b00, 1'b0, 8'h30 + 8'(wr_count), rb);
                    wr_count++;
                    repeat (i_gap) @(negedge i_clk_sys);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the DMA request and FIFO block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hdf_pkg::*;
;
    logic i_clk_sys, i_sys_rst, i_bus_rd, i_bus_wr, auto;
    logic [1:0] i_dma_mode, i_rx_message_complete_cmd, i_dma_acknowledge_in, i_fifo_sel;
    logic [1:0] o_tx_dma_request, o_rx_dma_request, i_tx_need, i_tx_pop, o_tx_avail;
    logic [1:0] i_rx_valid, o_rx_ready, i_rx_is_addr, i_rx_frame_start, i_rx_frame_end;
    logic [1:0] o_rx_pool_full_irq, o_rx_message_end_irq, o_rx_frame_overflow_irq;
    logic [7:0] i_bus_wdata, o_bus_rdata;
    logic [3:0] gap;
    logic [15:0] o_tx_data, i_rx_data, i_rx_status;
    int failures = 0, check_count = 0, acc_n, acc_at_req, ch1_req_n, stall_n;
    int pf_n[2], me_n[2], of_n[2];
    hdf_dma_if i_dut (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_dma_mode(i_dma_mode),
        .i_rx_message_complete_cmd(i_rx_message_complete_cmd),
        .i_dma_acknowledge_in(i_dma_acknowledge_in),
        .i_fifo_sel(i_fifo_sel),
        .i_bus_rd(i_bus_rd),
        .i_bus_wr(i_bus_wr),
        .i_bus_wdata(i_bus_wdata),
        .o_bus_rdata(o_bus_rdata),
        .o_tx_dma_request(o_tx_dma_request),
        .o_rx_dma_request(o_rx_dma_request),
        .i_tx_need(i_tx_need),
        .i_tx_pop(i_tx_pop),
        .o_tx_data(o_tx_data),
        .o_tx_avail(o_tx_avail),
        .i_rx_valid(i_rx_valid),
        .o_rx_ready(o_rx_ready),
        .i_rx_data(i_rx_data),
        .i_rx_is_addr(i_rx_is_addr),
        .i_rx_frame_start(i_rx_frame_start),
        .i_rx_frame_end(i_rx_frame_end),
        .i_rx_status(i_rx_status),
        .o_rx_pool_full_irq(o_rx_pool_full_irq),
        .o_rx_message_end_irq(o_rx_message_end_irq),
        .o_rx_frame_overflow_irq(o_rx_frame_overflow_irq)
    );
    hdf_dma_model i_dma (
        .i_clk_sys(i_clk_sys),
        .i_auto(auto),
        .i_gap(gap),
        .i_rx_req(o_rx_dma_request),
        .i_tx_req(o_tx_dma_request),
        .i_rdata(o_bus_rdata),
        .o_ack(i_dma_acknowledge_in),
        .o_sel(i_fifo_sel),
        .o_rd(i_bus_rd),
        .o_wr(i_bus_wr),
        .o_wdata(i_bus_wdata)
    );
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        for (int c = 0; c < 2; c++) begin
            pf_n[c] += int'(o_rx_pool_full_irq[c] === 1'b1);
            me_n[c] += int'(o_rx_message_end_irq[c] === 1'b1);
            of_n[c] += int'(o_rx_frame_overflow_irq[c] === 1'b1);
        end
        acc_n += int'(i_rx_valid[0] && o_rx_ready[0] === 1'b1);
        stall_n += int'(i_rx_valid[0] && o_rx_ready[0] === 1'b0);
        ch1_req_n += int'(o_rx_dma_request[1] === 1'b1);
        if (o_rx_dma_request[0] === 1'b1 && acc_at_req < 0) begin
            acc_at_req = acc_n;
        end
    end
    // =====================================================================
    // Comparison, closing and shared drivers.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic give_up(input string name);
        failures++;
        $display("CHECK FAILED %s expected done seen timeout", name);
        finish_test();
    endtask
    task automatic do_reset();
        i_sys_rst = 1'b1;
        {auto, gap, i_dma_mode, i_rx_message_complete_cmd, i_tx_need, i_tx_pop} = '0;
        {i_rx_valid, i_rx_data, i_rx_is_addr, i_rx_frame_start, i_rx_frame_end} = '0;
        gap = 4'hF;
        i_rx_status = 16'hA5A5;
        repeat (4) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        i_dma.rd_q.delete();
        i_dma.wr_count = 0;
        {acc_n, ch1_req_n, stall_n} = '0;
        acc_at_req = -1;
        pf_n = '{0, 0};
        me_n = '{0, 0};
        of_n = '{0, 0};
        @(negedge i_clk_sys);
    endtask
    // Address byte first, then n bytes counting up from base, the last one closing the frame.
    task automatic send_frame(input int ch, input int n, input logic [7:0] base);
        int w;
        i_rx_frame_start[ch] = 1'b1;
        @(negedge i_clk_sys);
        i_rx_frame_start[ch] = 1'b0;
        for (int k = -1; k < n; k++) begin
            i_rx_valid[ch] = 1'b1;
            i_rx_is_addr[ch] = (k < 0);
            i_rx_frame_end[ch] = (k == n - 1);
            i_rx_data[ch*8+:8] = (k < 0) ? 8'hFF : base + 8'(k);
            for (w = 0; w < 5000 && o_rx_ready[ch] !== 1'b1; w++) @(negedge i_clk_sys);
            if (w == 5000) give_up("rx_ready");
            @(negedge i_clk_sys);
        end
        i_rx_valid[ch] = 1'b0;
        i_rx_frame_end[ch] = 1'b0;
    endtask
    task automatic read_bytes(input int n, input logic [7:0] base, input logic st);
        logic [7:0] b;
        for (int k = 0; k < n; k++) begin
            i_dma.cycle(2'b00, 2'b10, 1'b1, 8'h00, b);
            check("cpu_byte", b, (st && k == n - 1) ? 8'hA5 : base + 8'(k));
        end
    endtask
    // =====================================================================
    // Scenarios.
    task automatic t_rx_dma();
        do_reset();
        i_dma_mode = 2'b01;
        auto = 1'b1;
        send_frame(0, 100, 8'h10);
        for (int w = 0; w < 9000 && i_dma.rd_q.size() < 101; w++) @(negedge i_clk_sys);
        if (i_dma.rd_q.size() < 101) give_up("dma_reads");
        repeat (60) @(negedge i_clk_sys);
        check("dma_reads", i_dma.rd_q.size(), 101);
        for (int k = 0; k < 101; k++) begin
            check("dma_byte", i_dma.rd_q[k], (k == 100) ? 8'hA5 : 8'h10 + 8'(k));
        end
        check("req_after_block", 32'(acc_at_req >= 33), 1);
        check("rx_stalled", 32'(stall_n > 0), 1);
        check("rx_req_low", o_rx_dma_request, 0);
        check("msg_end", me_n[0], 1);
        check("pool_full_dma", pf_n[0], 0);
        check("other_ch_req", ch1_req_n, 0);
        $display("test rx_dma done");
    endtask
    task automatic t_rx_irq();
        do_reset();
        check("req_after_reset", {o_tx_dma_request, o_rx_dma_request}, 0);
        send_frame(1, 40, 8'h40);
        repeat (40) @(negedge i_clk_sys);
        check("pool_full", pf_n[1], 1);
        check("irq_mode_req", o_rx_dma_request, 0);
        read_bytes(32, 8'h40, 1'b0);
        read_bytes(32, 8'h40, 1'b0);
        i_rx_message_complete_cmd[1] = 1'b1;
        @(negedge i_clk_sys);
        i_rx_message_complete_cmd[1] = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        read_bytes(9, 8'h60, 1'b1);
        check("msg_end_irq", me_n[1], 1);
        $display("test rx_irq done");
    endtask
    task automatic t_short();
        do_reset();
        for (int f = 0; f < 17; f++) send_frame(1, 1, 8'h70 + 8'(f));
        repeat (40) @(negedge i_clk_sys);
        check("no_overflow", of_n[1], 0);
        i_rx_frame_start[1] = 1'b1;
        @(negedge i_clk_sys);
        i_rx_frame_start[1] = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        check("overflow", of_n[1], 1);
        read_bytes(2, 8'h70, 1'b1);
        $display("test short_frames done");
    endtask
    task automatic t_tx_dma();
        do_reset();
        i_dma_mode = 2'b01;
        auto = 1'b1;
        i_tx_need = 2'b01;
        for (int w = 0; w < 5000 && i_dma.wr_count < 32; w++) @(negedge i_clk_sys);
        i_tx_need = 2'b00;
        repeat (40) @(negedge i_clk_sys);
        check("tx_writes", i_dma.wr_count, 32);
        check("tx_req_low", o_tx_dma_request, 0);
        auto = 1'b0;
        for (int k = 0; k < 32; k++) begin
            for (int w = 0; w < 200 && o_tx_avail[0] !== 1'b1; w++) @(negedge i_clk_sys);
            if (o_tx_avail[0] !== 1'b1) give_up("tx_avail");
            check("tx_byte", o_tx_data[7:0], 8'h30 + 8'(k));
            i_tx_pop = 2'b01;
            @(negedge i_clk_sys);
            i_tx_pop = 2'b00;
            @(negedge i_clk_sys);
        end
        $display("test tx_dma done");
    endtask
    initial begin
        do_reset();
        t_rx_dma();
        t_rx_irq();
        t_short();
        t_tx_dma();
        finish_test();
    end
endmodule
`default_nettype wire
